// >>> logic/dpc_pkg.sv
// Package: register map, field positions and reset values of the debug port block
`default_nettype none
package dpc_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    // Byte addresses of the registers
    localparam logic [ADDR_W-1:0] OFFS_IDENT = 4'h0;
    localparam logic [ADDR_W-1:0] OFFS_CTRL = 4'h4;
    // Control register field positions
    localparam int BIT_SCAN_EN = 3;
    localparam int BIT_TRACE_EN = 2;
    localparam int BIT_TDO_USE = 0;
    // Control register: bits at and above this width are unused
    localparam int CTRL_USED_W = 4;
    // Unused control bit between the used fields
    localparam int BIT_RESERVED = 1;
    // Avalon-MM response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // Control field reset values
    localparam logic RST_SCAN_EN = 1'h1;
    localparam logic RST_TRACE_EN = 1'h0;
    localparam logic RST_TDO_USE = 1'h0;
    // Identification field layout
    localparam int REV_LSB = 28;
    localparam int REV_W = 4;
    localparam int PART_W = 28;
    // Value returned for unmapped addresses
    localparam logic [DATA_W-1:0] UNMAPPED_DATA = 32'h0000_0000;
    // Zero word for read data reset
    localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
endpackage
`default_nettype wire

// >>> logic/dpc_flag.sv
// Single software writable flag bit with a reset value
`default_nettype none
module dpc_flag #(
    parameter logic RESET_VAL = 1'b0
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Write port
    input wire logic wr_en,
    input wire logic wr_data,
    // Stored value
    output logic flag_q
);
    logic flag_reg;
    logic flag_next;

    // Next value: load on write, else hold
    assign flag_next = wr_en ? wr_data : flag_reg;

    // Storage
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            flag_reg <= RESET_VAL;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign flag_q = flag_reg;
endmodule
`default_nettype wire

// >>> logic/dpc_ident.sv
// Read-only identification word built from fixed revision and part fields
`default_nettype none
module dpc_ident #(
    // Arbitrary identification values
    parameter logic [dpc_pkg::REV_W-1:0] REVISION = 4'h1,
    parameter logic [dpc_pkg::PART_W-1:0] PART_ID = 28'h0000ABC
) (
    // Identification word
    output logic [dpc_pkg::DATA_W-1:0] ident_word
);
    // Revision in the top nibble, part identifier below
    assign ident_word = {REVISION, PART_ID};
endmodule
`default_nettype wire

// >>> logic/dpc_debug_port.sv
// Debug port control and identification registers on an Avalon-MM slave
`default_nettype none
// =====================================================================
// Behaviour
// R1 - Scan port enable at bit 3, resets 1
// R2 - Trace output enable at bit 2, resets 0
// R3 - Two-wire uses TDO at bit 0, resets 0
// R4 - Control bits 31-4 and 1 read zero
// R5 - Identification bits 31-28 hold silicon revision
// R6 - Identification bits 27-0 hold part identifier
// R7 - Writes to identification register are ignored
module dpc_debug_port #(
    // Arbitrary identification values
    parameter logic [dpc_pkg::REV_W-1:0] REVISION = 4'h1,
    parameter logic [dpc_pkg::PART_W-1:0] PART_ID = 28'h0000ABC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Avalon-MM slave
    input wire logic [dpc_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [dpc_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [dpc_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    // Debug port controls
    output logic scan_port_enable,
    output logic trace_output_enable,
    output logic two_wire_uses_tdo
);
    // =================================================================
    // Bus handshake
    // Each access waits one cycle, then completes in the second cycle
    logic ack_reg;
    logic ack_next;
    wire req = avs_read | avs_write;
    assign ack_next = req & ~ack_reg;
    wire done = req & ack_reg;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= ack_next;
        end
    end

    // Waitrequest high except in the completing cycle
    logic wait_reg;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wait_reg <= 1'b1;
        end else begin
            wait_reg <= ~ack_next;
        end
    end
    assign avs_waitrequest = wait_reg;

    // =================================================================
    // Address decode
    wire sel_ident = (avs_address == dpc_pkg::OFFS_IDENT);
    wire sel_ctrl = (avs_address == dpc_pkg::OFFS_CTRL);
    wire ctrl_wr = done & avs_write & sel_ctrl & avs_byteenable[0];
    // Identification writes decode to nothing and change no state
    wire ident_wr_ignored = done & avs_write & sel_ident; // R7

    // =================================================================
    // Control flags
    logic scan_q;
    logic trace_q;
    logic tdo_q;

    dpc_flag #(.RESET_VAL(dpc_pkg::RST_SCAN_EN)) u_scan ( // R1
        .ref_clk(ref_clk),
        .reset(reset),
        .wr_en(ctrl_wr),
        .wr_data(avs_writedata[dpc_pkg::BIT_SCAN_EN]),
        .flag_q(scan_q)
    );

    dpc_flag #(.RESET_VAL(dpc_pkg::RST_TRACE_EN)) u_trace ( // R2
        .ref_clk(ref_clk),
        .reset(reset),
        .wr_en(ctrl_wr),
        .wr_data(avs_writedata[dpc_pkg::BIT_TRACE_EN]),
        .flag_q(trace_q)
    );

    dpc_flag #(.RESET_VAL(dpc_pkg::RST_TDO_USE)) u_tdo ( // R3
        .ref_clk(ref_clk),
        .reset(reset),
        .wr_en(ctrl_wr),
        .wr_data(avs_writedata[dpc_pkg::BIT_TDO_USE]),
        .flag_q(tdo_q)
    );

    // =================================================================
    // Identification word
    logic [dpc_pkg::DATA_W-1:0] ident_word;
    dpc_ident #(.REVISION(REVISION), .PART_ID(PART_ID)) u_ident ( // R5 R6
        .ident_word(ident_word)
    );

    // =================================================================
    // Read data
    // Control image: unimplemented bits forced to zero
    logic [dpc_pkg::DATA_W-1:0] ctrl_word;
    always_comb begin
        ctrl_word = dpc_pkg::ZERO_WORD; // R4
        ctrl_word[dpc_pkg::BIT_SCAN_EN] = scan_q;
        ctrl_word[dpc_pkg::BIT_TRACE_EN] = trace_q;
        ctrl_word[dpc_pkg::BIT_TDO_USE] = tdo_q;
    end

    wire [dpc_pkg::DATA_W-1:0] rd_mux = sel_ident ? ident_word :
        sel_ctrl ? ctrl_word : dpc_pkg::UNMAPPED_DATA;
    wire unmapped = ~(sel_ident | sel_ctrl);

    // Read data registered in the waiting cycle, shown in the completing one
    logic [dpc_pkg::DATA_W-1:0] rdata_reg;
    logic [1:0] resp_reg;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rdata_reg <= dpc_pkg::ZERO_WORD;
            resp_reg <= dpc_pkg::RESP_OKAY;
        end else if (ack_next) begin
            rdata_reg <= avs_read ? rd_mux : dpc_pkg::ZERO_WORD;
            resp_reg <= unmapped ? dpc_pkg::RESP_DECERR : dpc_pkg::RESP_OKAY;
        end
    end
    assign avs_readdata = rdata_reg;
    assign avs_response = resp_reg;

    // Debug controls straight from the flag registers
    assign scan_port_enable = scan_q; // R1
    assign trace_output_enable = trace_q; // R2
    assign two_wire_uses_tdo = tdo_q; // R3

    // =================================================================
    // Checks: helper terms
    // Flag outputs as one vector, in control register bit order
    wire [2:0] flag_vec = {scan_port_enable, trace_output_enable, two_wire_uses_tdo};
    // Completing accesses
    wire rd_done = done & avs_read;
    wire wr_done = done & avs_write;
    // Control write that the missing low byte lane turns away
    wire ctrl_wr_masked = wr_done & sel_ctrl & ~avs_byteenable[0];
    // Unused upper field of the control image as read back
    wire [dpc_pkg::DATA_W-dpc_pkg::CTRL_USED_W-1:0] rd_upper =
        avs_readdata[dpc_pkg::DATA_W-1:dpc_pkg::CTRL_USED_W];
    // Reset image of the three flags
    wire [2:0] flag_rst = {dpc_pkg::RST_SCAN_EN, dpc_pkg::RST_TRACE_EN, dpc_pkg::RST_TDO_USE};

    // =================================================================
    // Checks: reset
    // Scan port comes out of reset enabled
    a_scan_reset: assert property (@(posedge ref_clk) // R1
        $fell(reset) |-> scan_port_enable)
        else $error("scan enable not set after reset");

    // Trace output comes out of reset disabled
    a_trace_reset: assert property (@(posedge ref_clk) // R2
        $fell(reset) |-> !trace_output_enable)
        else $error("trace enable not clear after reset");

    // Two-wire link comes out of reset leaving TDO unused
    a_tdo_reset: assert property (@(posedge ref_clk) // R3
        $fell(reset) |-> !two_wire_uses_tdo)
        else $error("tdo use not clear after reset");

    // A reset edge puts every flag back to its reset value
    a_reset_flags: assert property (@(posedge ref_clk) // R1 R2 R3
        reset |=> (flag_vec == flag_rst))
        else $error("flags not at reset values");

    // A reset edge leaves the bus idle with no data and a clean response
    a_reset_bus: assert property (@(posedge ref_clk)
        reset |=> (avs_waitrequest && avs_readdata == dpc_pkg::ZERO_WORD &&
        avs_response == dpc_pkg::RESP_OKAY))
        else $error("bus outputs not idle after reset");

    // No request may complete at the first edge after reset
    a_wait_after_reset: assert property (@(posedge ref_clk)
        $fell(reset) |-> avs_waitrequest)
        else $error("waitrequest low right after reset");

    // =================================================================
    // Checks: handshake
    // A request seen while waitrequest is high
    sequence s_req_waiting;
        req && avs_waitrequest;
    endsequence

    // The master still holds its request
    sequence s_req_held;
        req;
    endsequence

    // Exactly one wait cycle: a held request completes at the next edge
    a_wait_single: assert property (@(posedge ref_clk) disable iff (reset)
        s_req_waiting ##1 s_req_held |-> !avs_waitrequest)
        else $error("held request not answered after one wait");

    // Waitrequest stays high while no request is made
    a_wait_idle: assert property (@(posedge ref_clk) disable iff (reset)
        !req |=> avs_waitrequest)
        else $error("waitrequest low without request");

    // Waitrequest is low for one cycle only
    a_wait_release: assert property (@(posedge ref_clk) disable iff (reset)
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");

    // A request is always answered within two edges
    a_wait_bounded: assert property (@(posedge ref_clk) disable iff (reset)
        (req && avs_waitrequest) |-> ##[1:2] !avs_waitrequest)
        else $error("waitrequest held too long");

    // Read data change only at the edge where a request is taken
    a_rdata_hold: assert property (@(posedge ref_clk) disable iff (reset)
        !ack_next |=> $stable(avs_readdata))
        else $error("read data changed outside a transfer");

    // =================================================================
    // Checks: control register
    // A control write that lands at this edge
    sequence s_ctrl_write;
        ctrl_wr;
    endsequence

    // A control read completing at this edge
    sequence s_ctrl_read;
        rd_done && sel_ctrl;
    endsequence

    // Scan enable follows its bit of an accepted control write
    a_scan_write: assert property (@(posedge ref_clk) disable iff (reset) // R1
        s_ctrl_write |=> scan_port_enable == $past(avs_writedata[dpc_pkg::BIT_SCAN_EN]))
        else $error("scan enable did not follow write");

    // Trace enable follows its bit of an accepted control write
    a_trace_write: assert property (@(posedge ref_clk) disable iff (reset) // R2
        s_ctrl_write |=> trace_output_enable == $past(avs_writedata[dpc_pkg::BIT_TRACE_EN]))
        else $error("trace enable did not follow write");

    // Two-wire TDO use follows its bit of an accepted control write
    a_tdo_write: assert property (@(posedge ref_clk) disable iff (reset) // R3
        s_ctrl_write |=> two_wire_uses_tdo == $past(avs_writedata[dpc_pkg::BIT_TDO_USE]))
        else $error("tdo use did not follow write");

    // Unused control bits read back as zero
    a_ctrl_zero_bits: assert property (@(posedge ref_clk) disable iff (reset) // R4
        (!avs_waitrequest && avs_read && sel_ctrl) |->
        (rd_upper == '0 && !avs_readdata[dpc_pkg::BIT_RESERVED]))
        else $error("control reserved bits not zero");

    // Flag bits read back as the live flag outputs
    a_ctrl_read_flags: assert property (@(posedge ref_clk) disable iff (reset) // R1 R2 R3
        s_ctrl_read |-> (avs_readdata[dpc_pkg::BIT_SCAN_EN] == scan_port_enable &&
        avs_readdata[dpc_pkg::BIT_TRACE_EN] == trace_output_enable &&
        avs_readdata[dpc_pkg::BIT_TDO_USE] == two_wire_uses_tdo))
        else $error("control read does not match flags");

    // Flags hold at every edge without an accepted control write
    a_flags_hold: assert property (@(posedge ref_clk) disable iff (reset) // R1 R2 R3 R7
        !ctrl_wr |=> $stable(flag_vec))
        else $error("flags changed without control write");

    // A control write without the low byte lane changes nothing
    a_lane_masked: assert property (@(posedge ref_clk) disable iff (reset)
        ctrl_wr_masked |=> $stable(flag_vec))
        else $error("masked control write changed flags");

    // =================================================================
    // Checks: identification and decode
    // Identification read returns the fixed revision and part fields
    a_ident_value: assert property (@(posedge ref_clk) disable iff (reset) // R5 R6
        (!avs_waitrequest && avs_read && sel_ident) |->
        (avs_readdata[dpc_pkg::REV_LSB +: dpc_pkg::REV_W] == REVISION &&
        avs_readdata[dpc_pkg::PART_W-1:0] == PART_ID))
        else $error("identification read wrong");

    // A write to the identification word leaves every flag alone
    a_ident_write: assert property (@(posedge ref_clk) disable iff (reset) // R7
        ident_wr_ignored |=> $stable({scan_port_enable, trace_output_enable,
        two_wire_uses_tdo}))
        else $error("identification write changed state");

    // Unmapped reads return the fixed filler word
    a_unmapped_zero: assert property (@(posedge ref_clk) disable iff (reset)
        (rd_done && unmapped) |-> avs_readdata == dpc_pkg::UNMAPPED_DATA)
        else $error("unmapped read not zero");

    // Unmapped accesses complete with a decode error
    a_resp_decode: assert property (@(posedge ref_clk) disable iff (reset)
        (done && unmapped) |-> avs_response == dpc_pkg::RESP_DECERR)
        else $error("unmapped access without decode error");

    // Mapped accesses complete with an okay response
    a_resp_okay: assert property (@(posedge ref_clk) disable iff (reset)
        ((rd_done || wr_done) && !unmapped) |-> avs_response == dpc_pkg::RESP_OKAY)
        else $error("mapped access without okay response");
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench for the debug port control and identification registers
`default_nettype none
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin error_cnt++; \
    $display("Error %s expected %h seen %h", nm, ex, gt); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // Arbitrary identification values
    localparam logic [3:0] REV_P = 4'h6;
    localparam logic [27:0] PART_P = 28'h0123459;
    localparam logic [31:0] ID_W = {REV_P, PART_P};
    typedef struct packed {
        logic wr;
        logic [3:0] addr;
        logic [31:0] wdata;
        logic [3:0] be;
        logic [31:0] rdata;
        logic [1:0] resp;
        logic [2:0] flags;
    } dpc_row_s;
    // ==========================================
    // Signals and design instance
    logic ref_clk, reset, avs_read, avs_write, avs_waitrequest;
    logic [3:0] avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [1:0] avs_response, rsp;
    logic scan_port_enable, trace_output_enable, two_wire_uses_tdo;
    int error_cnt = 0;
    int checks_done = 0;
    dpc_debug_port #(.REVISION(REV_P), .PART_ID(PART_P)) DUT (
        .ref_clk(ref_clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
        .scan_port_enable(scan_port_enable), .trace_output_enable(trace_output_enable),
        .two_wire_uses_tdo(two_wire_uses_tdo));
    wire logic [2:0] flags = {scan_port_enable, trace_output_enable, two_wire_uses_tdo};
    // Ordinary cases: request beside the answer and flag state it should give
    dpc_row_s rows [15] = '{
        '{1'b0, 4'h4, 32'h0, 4'hF, 32'h0000_0008, 2'h0, 3'h4},
        '{1'b0, 4'h0, 32'h0, 4'hF, ID_W, 2'h0, 3'h4},
        '{1'b1, 4'h4, 32'hFFFF_FFFF, 4'hF, 32'h0, 2'h0, 3'h7},
        '{1'b0, 4'h4, 32'h0, 4'hF, 32'h0000_000D, 2'h0, 3'h7},
        '{1'b1, 4'h0, 32'h0, 4'hF, 32'h0, 2'h0, 3'h7},
        '{1'b0, 4'h0, 32'h0, 4'hF, ID_W, 2'h0, 3'h7},
        '{1'b1, 4'h4, 32'hFFFF_FFF2, 4'hF, 32'h0, 2'h0, 3'h0},
        '{1'b0, 4'h4, 32'h0, 4'hF, 32'h0000_0000, 2'h0, 3'h0},
        '{1'b1, 4'h4, 32'h0000_0004, 4'hF, 32'h0, 2'h0, 3'h2},
        '{1'b0, 4'h4, 32'h0, 4'hF, 32'h0000_0004, 2'h0, 3'h2},
        '{1'b1, 4'h4, 32'h0000_0001, 4'hF, 32'h0, 2'h0, 3'h1},
        '{1'b1, 4'h4, 32'h0000_0008, 4'hF, 32'h0, 2'h0, 3'h4},
        '{1'b0, 4'h8, 32'h0, 4'hF, 32'h0000_0000, 2'h3, 3'h4},
        '{1'b1, 4'hC, 32'h0000_0007, 4'hF, 32'h0, 2'h3, 3'h4},
        '{1'b1, 4'h4, 32'h0000_0003, 4'hE, 32'h0, 2'h0, 3'h4}};
    // ==========================================
    // Clock
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // One Avalon-MM transfer, held until waitrequest is sampled low
    task automatic bus_xfer(input logic wr, input logic [3:0] addr, input logic [31:0] wd,
                            input logic [3:0] be);
        @(posedge ref_clk);
        avs_read <= ~wr;
        avs_write <= wr;
        avs_address <= addr;
        avs_writedata <= wd;
        avs_byteenable <= be;
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        rsp = avs_response;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask
    // Prints the counts and the verdict, then stops
    task automatic wrap_up();
        $display("Checks %0d, errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Watchdog against a hung handshake
    initial begin
        repeat (3000) @(posedge ref_clk);
        error_cnt++;
        wrap_up();
    end
    // ==========================================
    // Main sequence
    initial begin
        reset <= 1'b1;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_address <= 4'h0;
        avs_writedata <= 32'h0;
        avs_byteenable <= 4'hF;
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        `CHK("idle waitrequest", 1'b1, avs_waitrequest)
        `CHK("reset flags", 3'h4, flags)
        for (int i = 0; i < 15; i++) begin
            bus_xfer(rows[i].wr, rows[i].addr, rows[i].wdata, rows[i].be);
            if (!rows[i].wr) `CHK("read data", rows[i].rdata, rd)
            `CHK("response", rows[i].resp, rsp)
            `CHK("flags", rows[i].flags, flags)
        end
        // Ident write then read, with idle cycles between them, then a reset in mid-run
        bus_xfer(1'b1, 4'h0, 32'hFFFF_FFFF, 4'hF);
        bus_xfer(1'b0, 4'h0, 32'h0, 4'hF);
        `CHK("ident after write", ID_W, rd)
        bus_xfer(1'b1, 4'h4, 32'h0000_0005, 4'hF);
        `CHK("flags before reset", 3'h3, flags)
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        `CHK("flags after reset", 3'h4, flags)
        bus_xfer(1'b0, 4'h4, 32'h0, 4'hF);
        `CHK("ctrl after reset", 32'h0000_0008, rd)
        wrap_up();
    end
endmodule
`default_nettype wire
